// >>> pkg/pcrst_params.svh
`ifndef PCRST_PARAMS_SVH
`define PCRST_PARAMS_SVH

// Default timing of the reset sequencer and clock divider; counts are in clk_sys cycles
`define PCRST_CLK_PERIOD_NS    10
`define PCRST_LOCK_TIME_NS     200
`define PCRST_LOCK_CYCLES      (`PCRST_LOCK_TIME_NS / `PCRST_CLK_PERIOD_NS)
`define PCRST_HOLD_TIME_NS     80
`define PCRST_HOLD_CYCLES      ((`PCRST_HOLD_TIME_NS + `PCRST_CLK_PERIOD_NS - 1) / `PCRST_CLK_PERIOD_NS)
`define PCRST_DIV_RATIO        2

`endif

// >>> pkg/pcrst_pkg.sv
`default_nettype none
package pcrst_pkg;

    typedef enum logic [1:0] {
        PCRST_ST_RESET,
        PCRST_ST_WAIT_LOCK,
        PCRST_ST_HOLD,
        PCRST_ST_RUN
    } pcrst_state_t;

    // Reset requests entering the core, all active low
    typedef struct packed {
        logic pinRstN;
        logic softRstN;
    } pcrst_rst_in_t;

    // Status driven toward the application
    typedef struct packed {
        logic resetStatus;
        logic pllLocked;
        logic coreRstN;
    } pcrst_status_t;

endpackage
`default_nettype wire

// >>> hdl/pcrst_core_clock_reset.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcrst_params.svh"

module pcrst_core_clock_reset #(
    parameter int unsigned LOCK_CYCLES = `PCRST_LOCK_CYCLES,
    parameter int unsigned HOLD_CYCLES = `PCRST_HOLD_CYCLES,
    parameter int unsigned DIV_RATIO   = `PCRST_DIV_RATIO,
    parameter bit          PIPE_SIM    = 1'b0
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    clkEn,
    input  wire logic                    device_fundamental_reset_pin,
    input  wire logic                    softResetN,
    input  wire logic                    appClk,
    output var  logic                    coreClkOut,
    output var  pcrst_pkg::pcrst_status_t status,
    output var  logic                    appClkMismatch
);
    import pcrst_pkg::*;

    // Sequencer counters are 16 bits and the divider counts half periods in 8 bits
    if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65536 || HOLD_CYCLES < 1 || HOLD_CYCLES > 65536
        || DIV_RATIO < 2 || DIV_RATIO > 256 || (DIV_RATIO % 2) != 0) begin : badParams
        $error("pcrst_core_clock_reset: unsupported parameter value");
    end

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    pcrst_rst_in_t rstMeta_q;
    pcrst_rst_in_t rstSync_q;
    logic          appClkMeta_q;
    logic          appClkSync_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rstMeta_q    <= '0;
            rstSync_q    <= '0;
            appClkMeta_q <= 1'b0;
            appClkSync_q <= 1'b0;
        end else if (clkEn) begin
            rstMeta_q    <= '{pinRstN: device_fundamental_reset_pin, softRstN: softResetN};
            rstSync_q    <= rstMeta_q;
            appClkMeta_q <= appClk;
            appClkSync_q <= appClkMeta_q;
        end
    end

    // Either source alone holds the core in reset
    logic porN;
    assign porN = rstSync_q.pinRstN & rstSync_q.softRstN;

    // ************************************************************
    // Output clock divider
    // ************************************************************
    // The divided clock is only a model of the PLL output; real silicon uses
    // the PLL itself, so no logic here is clocked by it.
    logic [7:0] divCnt_q;
    logic       coreClk_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divCnt_q  <= 8'h00;
            coreClk_q <= 1'b0;
        end else if (clkEn) begin
            if (divCnt_q == 8'((DIV_RATIO / 2) - 1)) begin
                divCnt_q  <= 8'h00;
                coreClk_q <= ~coreClk_q;
            end else begin
                divCnt_q <= divCnt_q + 8'h01;
            end
        end
    end
    assign coreClkOut = coreClk_q;

    // Flags an application clock that does not follow the core clock
    logic [1:0] coreDly_q;
    logic       mismatch_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            coreDly_q  <= 2'h0;
            mismatch_q <= 1'b0;
        end else if (clkEn) begin
            coreDly_q  <= {coreDly_q[0], coreClk_q};
            mismatch_q <= porN & (appClkSync_q != coreDly_q[1]);
        end
    end
    assign appClkMismatch = mismatch_q;

    // ************************************************************
    // Reset sequencer
    // ************************************************************
    pcrst_state_t state_q;
    logic [15:0]  cnt_q;
    logic         locked_q;
    logic         resetStatus_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q  <= PCRST_ST_RESET;
            cnt_q    <= 16'h0000;
            locked_q <= 1'b0;
        end else if (clkEn) begin
            if (!porN) begin
                state_q  <= PCRST_ST_RESET;
                cnt_q    <= 16'h0000;
                locked_q <= 1'b0;
            end else begin
                case (state_q)
                    PCRST_ST_RESET: begin
                        state_q <= PCRST_ST_WAIT_LOCK;
                        cnt_q   <= 16'h0000;
                    end
                    PCRST_ST_WAIT_LOCK: begin
                        if (cnt_q == 16'(LOCK_CYCLES - 1)) begin
                            locked_q <= 1'b1;
                            state_q  <= PCRST_ST_HOLD;
                            cnt_q    <= 16'h0000;
                        end else begin
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end
                    PCRST_ST_HOLD: begin
                        if (cnt_q == 16'(HOLD_CYCLES - 1)) begin
                            state_q <= PCRST_ST_RUN;
                        end else begin
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end
                    PCRST_ST_RUN: begin
                        state_q <= PCRST_ST_RUN;
                    end
                    default: begin
                        state_q <= PCRST_ST_RESET;
                    end
                endcase
            end
        end
    end

    // Internal reset state is 0 only in RUN
    logic internalRst;
    assign internalRst = (state_q != PCRST_ST_RUN);

    // Raw power-on reset sets the indicator at once; release is clocked
    logic porAsync;
    assign porAsync = rst | ~(device_fundamental_reset_pin & softResetN);

    always_ff @(posedge clk_sys or posedge porAsync) begin
        if (porAsync) begin
            resetStatus_q <= 1'b1;
        end else if (clkEn) begin
            resetStatus_q <= ~porN | internalRst | ~locked_q;
        end
    end

    assign status.resetStatus = resetStatus_q;
    assign status.pllLocked   = PIPE_SIM ? 1'b1 : locked_q;
    assign status.coreRstN    = porN;

    // ************************************************************
    // Checks
    // ************************************************************
    chk_release_needs_run: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(resetStatus_q) |-> $past(state_q) == PCRST_ST_RUN && $past(porN))
        else $error("reset indicator released before core left reset");

    chk_por_sets_status: assert property (@(posedge clk_sys) disable iff (rst)
        !porN |-> resetStatus_q)
        else $error("reset indicator low during power-on reset");

    chk_unlocked_holds_rst: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && !locked_q) |=> resetStatus_q)
        else $error("reset indicator low while unlocked");

    chk_lock_after_wait: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(locked_q) |-> $past(state_q) == PCRST_ST_WAIT_LOCK)
        else $error("lock raised outside lock wait");

    chk_pipe_lock_high: assert property (@(posedge clk_sys) disable iff (rst)
        PIPE_SIM |-> status.pllLocked)
        else $error("lock indicator low in pipe simulation mode");

    chk_pin_resets_core: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && !rstSync_q.pinRstN) |=> state_q == PCRST_ST_RESET && !locked_q)
        else $error("pin reset did not reset the core");

    chk_soft_resets_core: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && !rstSync_q.softRstN) |=> state_q == PCRST_ST_RESET)
        else $error("soft reset did not reset the core");

    chk_clock_toggles: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && divCnt_q == 8'((DIV_RATIO / 2) - 1)) |=> $changed(coreClk_q))
        else $error("output clock did not toggle");

    // A raw reset arriving in that cycle sets the indicator again at once
    chk_release_clocked: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && state_q == PCRST_ST_RUN && porN && locked_q) |=> porAsync || !resetStatus_q)
        else $error("reset indicator not released in run");

    cov_reach_run: cover property (@(posedge clk_sys) disable iff (rst)
        $fell(resetStatus_q));
    cov_pin_reset_in_run: cover property (@(posedge clk_sys) disable iff (rst)
        state_q == PCRST_ST_RUN ##1 !rstSync_q.pinRstN);
    cov_soft_reset_in_run: cover property (@(posedge clk_sys) disable iff (rst)
        state_q == PCRST_ST_RUN ##1 !rstSync_q.softRstN);
    cov_mismatch: cover property (@(posedge clk_sys) disable iff (rst) mismatch_q);

endmodule
`default_nettype wire

// >>> testbench/pcrst_app_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Application side of the clock and reset interface
// ****************************************
module pcrst_app_model (
    input  wire logic coreClk,
    input  wire logic resetStatus,
    input  wire logic badClk,
    input  wire logic softReq,
    output var  logic appClk,
    output var  logic softResetN,
    output var  logic appInReset
);
    // Wrong clock only when a scenario asks for it
    assign appClk     = badClk ? ~coreClk : coreClk;
    // Idle high, so only the pin resets the core
    assign softResetN = ~softReq;
    assign appInReset = resetStatus;
endmodule
`default_nettype wire

// >>> testbench/test_pcie_core_clock_reset_interface.sv
`timescale 1ns/1ns
`default_nettype none
module test_pcie_core_clock_reset_interface;
    import pcrst_pkg::*;
    // ****************************************
    // Short counts keep each recovery brief
    // ****************************************
    localparam int LOCK = 4;
    localparam int HOLD = 3;
    logic          clk_sys, rst, clkEn, pinN, appClk, softResetN, coreClkOut;
    logic          appClkMismatch, badClk, softReq, appInReset, prevClk;
    pcrst_status_t status, status2;
    int            err_count, checks, seed, cycles, n, i;

    pcrst_core_clock_reset #(.LOCK_CYCLES(LOCK), .HOLD_CYCLES(HOLD)) dut (
        .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
        .device_fundamental_reset_pin(pinN), .softResetN(softResetN),
        .appClk(appClk), .coreClkOut(coreClkOut), .status(status),
        .appClkMismatch(appClkMismatch));
    pcrst_core_clock_reset #(.LOCK_CYCLES(LOCK), .HOLD_CYCLES(HOLD), .PIPE_SIM(1'b1)) dut2 (
        .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
        .device_fundamental_reset_pin(pinN), .softResetN(softResetN),
        .appClk(appClk), .coreClkOut(), .status(status2), .appClkMismatch());
    pcrst_app_model app (
        .coreClk(coreClkOut), .resetStatus(status.resetStatus), .badClk(badClk),
        .softReq(softReq), .appClk(appClk), .softResetN(softResetN),
        .appInReset(appInReset));

    initial begin
        clk_sys = 1'b0;
        // Reference clock held at its configured rate
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic int recoverMin();
        return LOCK + HOLD;
    endfunction

    // Slack covers the two sync flops and the state steps
    function automatic int recoverMax();
        return LOCK + HOLD + 6;
    endfunction

    task automatic final_report();
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi, input string what);
        checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("Error %0t: %s took %0d cycles", $time, what, got);
        end
    endtask

    task automatic recover(input int lo);
        n = 0;
        while (status.resetStatus !== 1'b0 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check_range(n, lo, recoverMax(), "recovery");
        check_bit(status.pllLocked, 1'b1, "lock after recovery");
        check_bit(status2.pllLocked, 1'b1, "pipe lock");
    endtask

    task automatic pulse(input bit usePin, input int width);
        @(negedge clk_sys);
        if (usePin) pinN = 1'b0;
        else softReq = 1'b1;
        #1;
        check_bit(status.resetStatus, 1'b1, "async set");
        repeat (width) @(negedge clk_sys);
        check_bit(status.coreRstN, 1'b0, "combined reset");
        check_bit(status.pllLocked, 1'b0, "lock dropped");
        pinN = 1'b1;
        softReq = 1'b0;
        recover(recoverMin());
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        rst = 1'b1; clkEn = 1'b1; pinN = 1'b0; badClk = 1'b0; softReq = 1'b0;
        seed = 97; err_count = 0; checks = 0; cycles = 0;
        repeat (10) @(negedge clk_sys);
        check_bit(status.resetStatus, 1'b1, "reset status");
        check_bit(status.coreRstN, 1'b0, "reset por");
        check_bit(coreClkOut, 1'b0, "reset clock");
        check_bit(status.pllLocked, 1'b0, "reset lock");
        check_bit(status2.pllLocked, 1'b1, "reset pipe lock");
        check_bit(appInReset, 1'b1, "app reset");
        rst = 1'b0;
        pinN = 1'b1;
        recover(recoverMin());
        for (i = 0; i < 4; i++) begin
            prevClk = coreClkOut;
            @(posedge clk_sys);
            #1;
            check_bit(coreClkOut, ~prevClk, "output clock toggle");
        end
        repeat (6) @(posedge clk_sys);
        #1;
        check_bit(appClkMismatch, 1'b0, "clock matched");
        @(negedge clk_sys) badClk = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check_bit(appClkMismatch, 1'b1, "clock wrong");
        @(negedge clk_sys) badClk = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        check_bit(appClkMismatch, 1'b0, "clock restored");
        pulse(1'b1, 3);
        pulse(1'b0, 3);
        for (i = 0; i < 6; i++) begin
            pulse(bit'($random(seed)), 3 + int'($unsigned($random(seed)) % 6));
        end
        // Frozen sequencer must not release the application early
        @(negedge clk_sys) pinN = 1'b0;
        repeat (3) @(negedge clk_sys);
        pinN = 1'b1;
        repeat (3) @(negedge clk_sys);
        clkEn = 1'b0;
        repeat (20) @(negedge clk_sys);
        check_bit(status.resetStatus, 1'b1, "frozen status");
        check_bit(status.pllLocked, 1'b0, "frozen lock");
        clkEn = 1'b1;
        recover(recoverMin() - 3);
        @(negedge clk_sys) rst = 1'b1;
        #1;
        check_bit(status.resetStatus, 1'b1, "second reset");
        @(negedge clk_sys) rst = 1'b0;
        recover(recoverMin());
        final_report();
    end
endmodule
`default_nettype wire
